// *** logic/ttbc_consts.vh ***
// register map, field positions and codes of the trace and break controller
`ifndef TTBC_CONSTS_VH
`define TTBC_CONSTS_VH
// register byte addresses
`define TTBC_OFS_CMPA   8'h00
`define TTBC_OFS_CMPB   8'h04
`define TTBC_OFS_CMPC   8'h08
`define TTBC_OFS_CTRL   8'h0c
`define TTBC_OFS_TRIG   8'h10
`define TTBC_OFS_STAT   8'h14
`define TTBC_OFS_FIFO   8'h20
`define TTBC_OFS_FEND   8'h3c
// debug_control_reg fields
`define TTBC_C_EN       7
`define TTBC_C_ARM      6
`define TTBC_C_TAG      5
`define TTBC_C_BRK      4
`define TTBC_C_COMP_A_RW_ENABLE    3
`define TTBC_C_RWA      2
`define TTBC_C_COMP_B_RW_ENABLE    1
`define TTBC_C_RWB      0
`define TTBC_C_LOOP     8
// trigger_config_reg fields
`define TTBC_T_QUAL     7
`define TTBC_T_BEGIN    6
// value word: ext byte holds address bit 16 and the paged flag
`define TTBC_V_PAGED    23
// trigger mode codes
`define TTBC_M_A        4'h0
`define TTBC_M_AORB     4'h1
`define TTBC_M_ATHENB   4'h2
`define TTBC_M_EVB      4'h3
`define TTBC_M_AEVB     4'h4
`define TTBC_M_AANDB    4'h5
`define TTBC_M_ANOTB    4'h6
`define TTBC_M_IN       4'h7
`define TTBC_M_OUT      4'h8
// fifo depth and full count
`define TTBC_FULL       4'h8
`endif

// *** logic/ttbc_comparator.v ***
// one address comparator with its own opcode tracking circuit
`timescale 1ns/10ps
module ttbc_comparator #(
    parameter W = 17
) (
    // clock and reset
    input  wire         clk,
    input  wire         rst,
    // compare value and bus
    input  wire [W-1:0] value,
    input  wire [W-1:0] addr,
    input  wire         cyc,
    input  wire         rw_ok,
    // instruction queue tracking
    input  wire         opfetch,
    input  wire         exec,
    input  wire [W-1:0] exec_addr,
    input  wire         flush,
    // results
    output wire         match,
    output wire         qual
);

    reg pend_reg;
    reg pend_next;

    // full-width equality on each bus cycle
    assign match = cyc && rw_ok && (addr == value);

    // opcode fetched at the compare address, later confirmed executed
    assign qual = pend_reg && exec && (exec_addr == value);

    always @* begin
        pend_next = pend_reg;
        if (flush || qual)
            pend_next = 1'b0;
        if (match && opfetch)
            pend_next = 1'b1;
    end

    // tracking state
    always @(posedge clk) begin
        if (rst)
            pend_reg <= 1'b0;
        else
            pend_reg <= pend_next;
    end

endmodule

// *** logic/ttbc_top.v ***
// trace trigger and break controller with apb registers and capture fifo
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/10ps
`include "ttbc_consts.vh"
// Functional notes
// - arming, triggering and storing only while the module enable bit is set
// - A and C compare address with 17-bit values; all matches reach controller
// - B compares address, or data against its low byte in full modes
// - full modes use A read/write controls for A and B; B's ignored
// - loop-once mode makes C track last capture outside event-only modes, not a breakpoint
// - arming with enable in loop-once mode clears comparator C value, unless a capture in the arming cycle loads it
// - loop-once, except event-only modes: equal to C suppresses capture, else store and load C
// - C update copies paged access indicator into paged select flag
// - end-of-run break request only with break enable set
// - begin run breaks at 8 words, end run breaks at trigger
// - kind select 0 gives force-type break request
// - kind select 1 enters a tag into instruction queue, except the begin-run full break, which stays force-type
// - break enable and kind apply to all three comparators
// - qualify select requires opcode execution for A trigger, and for B outside full modes, except in event-only modes
// - each comparator owns its own opcode tracker
// - end runs: raw match breaks, qualified signal stops capture
// - begin runs: qualified signal starts capture, break when full
// - begin trigger stores until 8 locations filled, then stops
// - end trigger stores until trigger, oldest dropped beyond 8
// - mode 0101 is A and B same cycle, 0110 A and not B
// - arm and its image clear at end trigger or begin fifo full
// - event-only modes always behave as begin-trigger runs
module ttbc_top #(
    parameter AW = 17,
    parameter DEPTH = 8
) (
    // clock and reset
    input  wire          REF_CLK,
    input  wire          RESET,
    // apb slave
    input  wire          PSEL,
    input  wire          PENABLE,
    input  wire          PWRITE,
    input  wire [7:0]    PADDR,
    input  wire [31:0]   PWDATA,
    output wire          PREADY,
    output wire          PSLVERR,
    output reg  [31:0]   PRDATA,
    // core buses
    input  wire          CORE_CYC,
    input  wire [AW-1:0] CORE_ADDR,
    input  wire          CORE_RW,
    input  wire [7:0]    CORE_RDATA,
    input  wire [7:0]    CORE_WDATA,
    input  wire [1:0]    CORE_COF,
    input  wire          CORE_PAGED_ACCESS_INDICATOR,
    // instruction queue
    input  wire          CORE_OPFETCH,
    input  wire          CORE_EXEC,
    input  wire [AW-1:0] CORE_EXEC_ADDR,
    input  wire          CORE_FLUSH,
    // break requests
    output reg           BRK_FORCE,
    output reg           BRK_TAG
);

    localparam PW = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////////
    // registers
    reg  [23:0]   cmpa_reg;
    reg  [23:0]   cmpb_reg;
    reg  [23:0]   cmpc_reg;
    reg  [8:0]    ctrl_reg;
    reg  [7:0]    trig_reg;
    reg  [2:0]    flag_reg;
    reg  [3:0]    cnt_reg;
    reg  [PW-1:0] wptr_reg;
    reg  [AW:0]   fifo_reg [0:DEPTH-1];
    reg  [AW-1:0] prev_reg;
    reg           seq_reg;
    reg           go_reg;
    reg           arm_q_reg;
    wire          en;
    wire          armed;
    wire          loop_once_capture_mode;
    wire          full_m;
    wire          ev_m;
    wire          begin_eff;
    wire          wr;
    wire          rd_setup;
    wire          mapped;
    wire [3:0]    mode;
    wire          rwa_ok;
    wire          rwb_ok;
    wire          ma;
    wire          mb_addr;
    wire          mc;
    wire          qa;
    wire          qb;
    wire          qc_unused;
    wire          mb;
    wire          ta;
    wire          tb;
    wire [7:0]    dbus;
    wire          range_in;
    reg           trig_raw;
    reg           trig_q;
    reg           store;
    reg  [AW:0]   word;
    wire          cof_any;
    wire          dup;
    wire          fill_done;
    wire          arm_rise;
    integer       i;

    assign en = ctrl_reg[`TTBC_C_EN];
    assign armed = en && ctrl_reg[`TTBC_C_ARM];
    assign loop_once_capture_mode = ctrl_reg[`TTBC_C_LOOP];
    assign mode = trig_reg[3:0];
    assign full_m = (mode == `TTBC_M_AANDB) || (mode == `TTBC_M_ANOTB);
    assign ev_m = (mode == `TTBC_M_EVB) || (mode == `TTBC_M_AEVB);
    assign begin_eff = trig_reg[`TTBC_T_BEGIN] || ev_m;

    ////////////////////////////////////////////////////////////////////////
    // comparators
    // full modes: A controls choose direction for both A and B
    assign rwa_ok = !ctrl_reg[`TTBC_C_COMP_A_RW_ENABLE] || (CORE_RW == ctrl_reg[`TTBC_C_RWA]);
    assign rwb_ok = full_m ? rwa_ok :
                    (!ctrl_reg[`TTBC_C_COMP_B_RW_ENABLE] || (CORE_RW == ctrl_reg[`TTBC_C_RWB]));
    // write data bus only when enable 1 and select 0
    assign dbus = (ctrl_reg[`TTBC_C_COMP_A_RW_ENABLE] && !ctrl_reg[`TTBC_C_RWA]) ?
                  CORE_WDATA : CORE_RDATA;

    ttbc_comparator #(.W(AW)) u_cmpa (
        .clk       (REF_CLK),
        .rst       (RESET),
        .value     (cmpa_reg[AW-1:0]),
        .addr      (CORE_ADDR),
        .cyc       (CORE_CYC && armed),
        .rw_ok     (rwa_ok),
        .opfetch   (CORE_OPFETCH),
        .exec      (CORE_EXEC),
        .exec_addr (CORE_EXEC_ADDR),
        .flush     (CORE_FLUSH),
        .match     (ma),
        .qual      (qa)
    );

    ttbc_comparator #(.W(AW)) u_cmpb (
        .clk       (REF_CLK),
        .rst       (RESET),
        .value     (cmpb_reg[AW-1:0]),
        .addr      (CORE_ADDR),
        .cyc       (CORE_CYC && armed),
        .rw_ok     (rwb_ok),
        .opfetch   (CORE_OPFETCH),
        .exec      (CORE_EXEC),
        .exec_addr (CORE_EXEC_ADDR),
        .flush     (CORE_FLUSH),
        .match     (mb_addr),
        .qual      (qb)
    );

    ttbc_comparator #(.W(AW)) u_cmpc (
        .clk       (REF_CLK),
        .rst       (RESET),
        .value     (cmpc_reg[AW-1:0]),
        .addr      (CORE_ADDR),
        .cyc       (CORE_CYC && en && !loop_once_capture_mode),
        .rw_ok     (1'b1),
        .opfetch   (CORE_OPFETCH),
        .exec      (CORE_EXEC),
        .exec_addr (CORE_EXEC_ADDR),
        .flush     (CORE_FLUSH),
        .match     (mc),
        .qual      (qc_unused)
    );

    // data compare against low byte in full modes
    assign mb = full_m ? (CORE_CYC && armed && rwb_ok && (dbus == cmpb_reg[7:0]))
                       : mb_addr;
    // qualified trigger inputs, event-only modes exempt, and B in full modes
    assign ta = (trig_reg[`TTBC_T_QUAL] && !ev_m) ? qa : ma;
    assign tb = (trig_reg[`TTBC_T_QUAL] && !ev_m && !full_m) ? qb : mb;
    assign range_in = (CORE_ADDR >= cmpa_reg[AW-1:0]) && (CORE_ADDR <= cmpb_reg[AW-1:0]);

    // trigger decode by mode; raw for break, qualified for fifo
    always @* begin
        trig_raw = 1'b0;
        trig_q = 1'b0;
        case (mode)
            `TTBC_M_A: begin
                trig_raw = ma;
                trig_q = ta;
            end
            `TTBC_M_AORB: begin
                trig_raw = ma || mb;
                trig_q = ta || tb;
            end
            `TTBC_M_ATHENB, `TTBC_M_AEVB: begin
                trig_raw = seq_reg && mb;
                trig_q = seq_reg && tb;
            end
            `TTBC_M_EVB: begin
                trig_raw = mb;
                trig_q = mb;
            end
            `TTBC_M_AANDB: begin
                trig_raw = ma; // tag break uses A only
                trig_q = ta && mb;
            end
            `TTBC_M_ANOTB: begin
                trig_raw = ma;
                trig_q = ta && !mb && CORE_CYC;
            end
            `TTBC_M_IN: begin
                trig_raw = CORE_CYC && armed && range_in;
                trig_q = trig_raw;
            end
            `TTBC_M_OUT: begin
                trig_raw = CORE_CYC && armed && !range_in;
                trig_q = trig_raw;
            end
            default: begin
                trig_raw = 1'b0;
                trig_q = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // capture
    assign cof_any = CORE_CYC && (CORE_COF != 2'b00);
    // word to capture: read data in event-only modes, else destination or branch source
    always @* begin
        word = {CORE_PAGED_ACCESS_INDICATOR, CORE_ADDR};
        if (ev_m)
            word = {{(AW-7){1'b0}}, CORE_RDATA};
        else if (!CORE_COF[1])
            word = {CORE_PAGED_ACCESS_INDICATOR, prev_reg - {{(AW-2){1'b0}}, 2'b10}};
    end
    assign dup = loop_once_capture_mode && !arm_rise && (word[AW-1:0] == cmpc_reg[AW-1:0]);
    // storing window: end runs until trigger, begin runs after it
    always @* begin
        store = 1'b0;
        if (armed && ev_m) begin
            store = trig_q; // data at the event, first event included
        end else if (armed && (!begin_eff || go_reg)) begin
            store = cof_any && !dup;
        end
        if (!begin_eff && trig_q)
            store = 1'b0;
    end
    assign fill_done = begin_eff && store && (cnt_reg == `TTBC_FULL - 4'h1);
    assign arm_rise = armed && !arm_q_reg;

    // fifo storage, circular so oldest falls out
    always @(posedge REF_CLK) begin
        if (RESET) begin
            wptr_reg <= {PW{1'b0}};
            for (i = 0; i < DEPTH; i = i + 1)
                fifo_reg[i] <= {(AW+1){1'b0}};
        end else if (store) begin
            fifo_reg[wptr_reg] <= word;
            wptr_reg <= wptr_reg + {{(PW-1){1'b0}}, 1'b1};
        end
    end

    // valid count, saturating at eight
    always @(posedge REF_CLK) begin
        if (RESET)
            cnt_reg <= 4'h0;
        else if (arm_rise)
            cnt_reg <= {3'h0, store}; // a store in the arming cycle still counts
        else if (store && cnt_reg != `TTBC_FULL)
            cnt_reg <= cnt_reg + 4'h1;
    end

    // run state: sequence, begin-run started, previous address
    always @(posedge REF_CLK) begin
        if (RESET) begin
            seq_reg <= 1'b0;
            go_reg <= 1'b0;
            arm_q_reg <= 1'b0;
            prev_reg <= {AW{1'b0}};
        end else begin
            arm_q_reg <= armed;
            if (CORE_CYC)
                prev_reg <= CORE_ADDR;
            if (!armed) begin
                seq_reg <= 1'b0;
                go_reg <= 1'b0;
            end else begin
                if (ta)
                    seq_reg <= 1'b1;
                if (begin_eff && trig_q)
                    go_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // break requests
    always @(posedge REF_CLK) begin
        if (RESET) begin
            BRK_FORCE <= 1'b0;
            BRK_TAG <= 1'b0;
        end else begin
            BRK_FORCE <= 1'b0;
            BRK_TAG <= 1'b0;
            if (en && ctrl_reg[`TTBC_C_BRK]) begin
                if (begin_eff) begin
                    if (fill_done)
                        BRK_FORCE <= 1'b1;
                end else if (armed && trig_raw) begin
                    BRK_FORCE <= !ctrl_reg[`TTBC_C_TAG];
                    BRK_TAG <= ctrl_reg[`TTBC_C_TAG];
                end
                if (mc) begin
                    BRK_FORCE <= !ctrl_reg[`TTBC_C_TAG];
                    BRK_TAG <= ctrl_reg[`TTBC_C_TAG];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states
    assign wr = PSEL && PENABLE && PWRITE;
    assign rd_setup = PSEL && !PENABLE && !PWRITE;
    assign mapped = (PADDR[1:0] == 2'b00) && ((PADDR <= `TTBC_OFS_STAT) ||
                    ((PADDR >= `TTBC_OFS_FIFO) && (PADDR <= `TTBC_OFS_FEND)));
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;

    // control, trigger config, comparator values and flags
    always @(posedge REF_CLK) begin
        if (RESET) begin
            cmpa_reg <= 24'h0;
            cmpb_reg <= 24'h0;
            cmpc_reg <= 24'h0;
            ctrl_reg <= 9'h0;
            trig_reg <= 8'h0;
            flag_reg <= 3'h0;
        end else begin
            if (wr && PADDR == `TTBC_OFS_CMPA)
                cmpa_reg <= PWDATA[23:0];
            if (wr && PADDR == `TTBC_OFS_CMPB)
                cmpb_reg <= PWDATA[23:0];
            if (wr && PADDR == `TTBC_OFS_CMPC)
                cmpc_reg <= PWDATA[23:0];
            // config locked while armed
            if (wr && PADDR == `TTBC_OFS_TRIG && !ctrl_reg[`TTBC_C_ARM])
                trig_reg <= PWDATA[7:0];
            // auto disarm at end of run
            if ((!begin_eff && trig_q && armed) || fill_done)
                ctrl_reg[`TTBC_C_ARM] <= 1'b0;
            if (wr && PADDR == `TTBC_OFS_CTRL)
                ctrl_reg <= PWDATA[8:0];
            // loop-once tracking owns comparator C
            if (loop_once_capture_mode && store && !ev_m)
                cmpc_reg <= {word[AW], {(23-AW){1'b0}}, word[AW-1:0]};
            else if (arm_rise && loop_once_capture_mode)
                cmpc_reg <= 24'h0;
            // match flags, cleared on arming, set wins
            if (armed)
                flag_reg <= (arm_rise ? 3'h0 : flag_reg) | {ma && !full_m ||
                                        trig_q && full_m, mb && !full_m ||
                                        trig_q && full_m, mc};
        end
    end

    // read data captured in the setup phase
    always @(posedge REF_CLK) begin
        if (RESET)
            PRDATA <= 32'h0;
        else if (rd_setup) begin
            PRDATA <= 32'h0;
            case (PADDR)
                `TTBC_OFS_CMPA: PRDATA <= {8'h0, cmpa_reg};
                `TTBC_OFS_CMPB: PRDATA <= {8'h0, cmpb_reg};
                `TTBC_OFS_CMPC: PRDATA <= {8'h0, cmpc_reg};
                `TTBC_OFS_CTRL: PRDATA <= {23'h0, ctrl_reg};
                `TTBC_OFS_TRIG: PRDATA <= {24'h0, trig_reg};
                `TTBC_OFS_STAT: PRDATA <= {{(21-PW){1'b0}}, wptr_reg, cnt_reg, flag_reg, 3'h0, armed};
                default: begin
                    if (PADDR >= `TTBC_OFS_FIFO && PADDR <= `TTBC_OFS_FEND)
                        PRDATA <= {{(31-AW){1'b0}}, fifo_reg[PADDR[4:2]]};
                end
            endcase
        end
    end

endmodule

// *** bench/ttbc_core_model.sv ***
// behavioural core bus and instruction queue driver
`timescale 1ns/10ps
module ttbc_core_model (
    // clock
    input  wire logic        clk,
    // core buses
    output logic             cyc,
    output logic [16:0]      addr,
    output logic             rw,
    output logic [7:0]       rdata,
    output logic [7:0]       wdata,
    output logic [1:0]       cof,
    output logic             paged_access_indicator,
    // instruction queue
    output logic             opf,
    output logic             exec,
    output logic [16:0]      exec_addr,
    output logic             flush
);
    // quiet bus at time zero, queue never flushed
    initial begin
        cyc = 1'b0;
        addr = 17'h00000;
        rw = 1'b1;
        rdata = 8'h00;
        wdata = 8'h00;
        cof = 2'h0;
        paged_access_indicator = 1'b0;
        opf = 1'b0;
        exec = 1'b0;
        exec_addr = 17'h00000;
        flush = 1'b0;
    end
    // one bus cycle; read bus carries the inverse so a wrong bus choice shows
    task automatic bus(input logic [16:0] a, input logic r, input logic [7:0] d, input logic [1:0] c,
                       input logic pp);
        cyc <= 1'b1;
        addr <= a;
        rw <= r;
        rdata <= ~d;
        wdata <= d;
        cof <= c;
        paged_access_indicator <= pp;
        opf <= 1'b1;
        @(posedge clk);
    endtask
    // one instruction reaches execution
    task automatic run_op(input logic [16:0] a);
        exec <= 1'b1;
        exec_addr <= a;
        @(posedge clk);
    endtask
    // released bus: no stale address, data or exec address left standing; rw and paged flag kept
    task automatic idle;
        cyc <= 1'b0;
        addr <= ~addr;
        rdata <= ~rdata;
        wdata <= ~wdata;
        cof <= 2'h0;
        opf <= 1'b0;
        exec <= 1'b0;
        exec_addr <= ~exec_addr;
        @(posedge clk);
    endtask
endmodule

// *** bench/ttbc_chk.sv ***
// port assertions for the trace trigger and break controller
`timescale 1ns/10ps
`include "ttbc_consts.vh"
module ttbc_chk (
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RESET,
    // apb
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic        PREADY,
    input  wire logic        PSLVERR,
    input  wire logic [31:0] PRDATA,
    // core and breaks
    input  wire logic        CORE_CYC,
    input  wire logic        BRK_FORCE,
    input  wire logic        BRK_TAG
);
    logic [8:0] ctrl_reg;
    logic [7:0] trig_reg;
    logic       mapped;
    logic       begin_run;
    // shadows of control and trigger writes
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            ctrl_reg <= 9'h000;
            trig_reg <= 8'h00;
        end else begin
            if (PSEL && PENABLE && PWRITE && PADDR == `TTBC_OFS_CTRL)
                ctrl_reg <= PWDATA[8:0];
            if (PSEL && PENABLE && PWRITE && PADDR == `TTBC_OFS_TRIG)
                trig_reg <= PWDATA[7:0];
        end
    end
    // decoded map and effective run type
    assign mapped = PADDR[1:0] == 2'h0 &&
                    (PADDR <= `TTBC_OFS_STAT || (PADDR >= `TTBC_OFS_FIFO && PADDR <= `TTBC_OFS_FEND));
    assign begin_run = trig_reg[`TTBC_T_BEGIN] || trig_reg[3:0] == `TTBC_M_EVB || trig_reg[3:0] == `TTBC_M_AEVB;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    chk_ready_high: assert property (PREADY) else $error("pready low");
    chk_err_unmapped: assert property (PSEL && PENABLE |-> PSLVERR == !mapped) else $error("pslverr wrong");
    chk_err_idle: assert property (!(PSEL && PENABLE) |-> !PSLVERR) else $error("pslverr outside access");
    chk_rdata_hold: assert property (!$past(PSEL && !PENABLE) |-> $stable(PRDATA)) else $error("prdata moved");
    chk_force_cause: assert property (BRK_FORCE |->
        $past(ctrl_reg[7] && ctrl_reg[4] && !ctrl_reg[5])) else $error("force break without enable");
    chk_tag_cause: assert property (BRK_TAG |-> $past(ctrl_reg[7] && ctrl_reg[4] && ctrl_reg[5]))
        else $error("tag break without enable");
    chk_break_bus: assert property (BRK_FORCE || BRK_TAG |-> $past(CORE_CYC))
        else $error("break without bus cycle");
    chk_tag_begin: assert property (BRK_TAG |-> !$past(begin_run))
        else $error("tag break in begin run");
    chk_one_kind: assert property (!(BRK_FORCE && BRK_TAG))
        else $error("both break kinds");
endmodule
bind ttbc_top ttbc_chk u_chk (.REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA), .CORE_CYC(CORE_CYC),
    .BRK_FORCE(BRK_FORCE), .BRK_TAG(BRK_TAG));

// *** bench/ttbc_tb_top.sv ***
// self-checking bench for the trace trigger and break controller
`timescale 1ns/10ps
`include "ttbc_consts.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module trace_trigger_break_control_tb_top;
    logic REF_CLK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, PREADY, PSLVERR, er;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rv;
    logic cyc, rw, pp, opf, ex, fl, BRK_FORCE, BRK_TAG;
    logic [16:0] ad, exa;
    logic [7:0] rd_d, wr_d;
    logic [1:0] cof;
    int n_fail = 0, compares = 0, nf = 0, nt = 0, f0, t0, tick = 0;
    ttbc_core_model u_core (.clk(REF_CLK), .cyc(cyc), .addr(ad), .rw(rw), .rdata(rd_d), .wdata(wr_d), .cof(cof),
        .paged_access_indicator(pp), .opf(opf), .exec(ex), .exec_addr(exa), .flush(fl));
    ttbc_top u_dut (.REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA), .CORE_CYC(cyc), .CORE_ADDR(ad),
        .CORE_RW(rw), .CORE_RDATA(rd_d), .CORE_WDATA(wr_d), .CORE_COF(cof), .CORE_PAGED_ACCESS_INDICATOR(pp), .CORE_OPFETCH(opf),
        .CORE_EXEC(ex), .CORE_EXEC_ADDR(exa), .CORE_FLUSH(fl), .BRK_FORCE(BRK_FORCE), .BRK_TAG(BRK_TAG));
    // clock
    initial forever #20 REF_CLK = ~REF_CLK;
    // break pulse counters and hang guard
    always @(posedge REF_CLK) begin
        nf += (BRK_FORCE === 1'b1);
        nt += (BRK_TAG === 1'b1);
        tick++;
        if (tick == 20000) begin
            n_fail++;
            complete_run;
        end
    end
    task complete_run;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one apb transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        @(posedge REF_CLK);
        while (PREADY !== 1'b1)
            @(posedge REF_CLK);
        rv = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge REF_CLK);
    endtask
    // disarm, set trigger, then arm; snapshot break counts
    task automatic arm(input logic [7:0] t, input logic [8:0] c);
        apb(1'b1, `TTBC_OFS_CTRL, 32'h0);
        apb(1'b1, `TTBC_OFS_TRIG, {24'h0, t});
        apb(1'b1, `TTBC_OFS_CTRL, {23'h0, c});
        f0 = nf;
        t0 = nt;
    endtask
    task automatic settle;
        u_core.idle();
        repeat (3) @(posedge REF_CLK);
    endtask
    task automatic t_regs;
        apb(1'b0, `TTBC_OFS_STAT, 32'h0);
        `CHK(rv, 32'h0)
        apb(1'b1, `TTBC_OFS_CMPA, 32'h0001_2345);
        apb(1'b0, `TTBC_OFS_CMPA, 32'h0);
        `CHK(rv, 32'h0001_2345)
        apb(1'b1, 8'h18, 32'hffff_ffff);
        `CHK(er, 1'b1)
        $display("registers done");
    endtask
    task automatic t_end;
        logic [7:0] tr [4] = '{8'h01, 8'h81, 8'h01, 8'h01};
        logic [8:0] ct [4] = '{9'h0d0, 9'h0f0, 9'h0c0, 9'h050};
        for (int i = 0; i < 4; i++) begin
            arm(tr[i], ct[i]);
            u_core.bus(17'h02345, 1'b1, 8'h00, 2'h0, 1'b0);
            settle;
            `CHK(nf - f0, 0)
            u_core.bus(17'h12345, 1'b1, 8'h00, 2'h0, 1'b0);
            settle;
            `CHK(nf - f0, int'(i == 0))
            `CHK(nt - t0, int'(i == 1))
            apb(1'b0, `TTBC_OFS_STAT, 32'h0);
            `CHK(rv[0], i == 1)
            u_core.run_op(17'h12345);
            settle;
            apb(1'b0, `TTBC_OFS_STAT, 32'h0);
            `CHK(rv[0], 1'b0)
        end
        $display("end runs done");
    endtask
    task automatic t_full;
        logic [3:0] md [4] = '{4'h5, 4'h5, 4'h6, 4'h6};
        logic [7:0] dt [4] = '{8'h5a, 8'h00, 8'h00, 8'h5a};
        apb(1'b1, `TTBC_OFS_CMPB, 32'h0000_005a);
        for (int i = 0; i < 4; i++) begin
            arm({4'h0, md[i]}, 9'h0cb);
            u_core.bus(17'h12345, 1'b0, dt[i], 2'h0, 1'b0);
            settle;
            apb(1'b0, `TTBC_OFS_STAT, 32'h0);
            `CHK(rv[0], i[0])
        end
        $display("full modes done");
    endtask
    task automatic t_begin;
        arm(8'h40, 9'h0d0);
        u_core.bus(17'h12345, 1'b1, 8'h00, 2'h0, 1'b0);
        for (int i = 0; i < 9; i++) begin
            u_core.bus(17'h00100 + 17'(i * 4), 1'b1, 8'h00, 2'h2, 1'b0);
            if (i == 6 || i == 8) begin
                settle;
                `CHK(nf - f0, int'(i == 8))
                apb(1'b0, `TTBC_OFS_STAT, 32'h0);
                `CHK({rv[10:7], rv[0]}, i == 6 ? 5'h0f : 5'h10)
            end
        end
        apb(1'b0, `TTBC_OFS_FIFO, 32'h0);
        `CHK(rv[16:0], 17'h00100)
        $display("begin run done");
    endtask
    task automatic t_wrap;
        arm(8'h00, 9'h0c0);
        for (int i = 0; i < 10; i++)
            u_core.bus(17'h00200 + 17'(i * 2), 1'b1, 8'h00, 2'h2, 1'b0);
        u_core.bus(17'h12345, 1'b1, 8'h00, 2'h0, 1'b0);
        settle;
        apb(1'b0, `TTBC_OFS_STAT, 32'h0);
        `CHK({rv[13:7], rv[0]}, 8'h50)
        apb(1'b0, `TTBC_OFS_FIFO + 8'h08, 32'h0);
        `CHK(rv[16:0], 17'h00204)
        $display("end wrap done");
    endtask
    task automatic t_loop;
        apb(1'b1, `TTBC_OFS_CMPC, 32'h0000_1111);
        arm(8'h00, 9'h1c0);
        apb(1'b0, `TTBC_OFS_CMPC, 32'h0);
        `CHK(rv, 32'h0)
        u_core.bus(17'h00300, 1'b1, 8'h00, 2'h2, 1'b0);
        u_core.bus(17'h00300, 1'b1, 8'h00, 2'h2, 1'b0);
        u_core.bus(17'h10400, 1'b1, 8'h00, 2'h2, 1'b1);
        settle;
        apb(1'b0, `TTBC_OFS_STAT, 32'h0);
        `CHK(rv[10:7], 4'h2)
        apb(1'b0, `TTBC_OFS_CMPC, 32'h0);
        `CHK(rv, 32'h0081_0400)
        $display("loop capture done");
    endtask
    task automatic t_event;
        arm(8'h03, 9'h0c0);
        u_core.bus(17'h0005a, 1'b1, 8'h3c, 2'h0, 1'b0);
        settle;
        apb(1'b0, `TTBC_OFS_STAT, 32'h0);
        `CHK({rv[10:7], rv[0]}, 5'h03)
        apb(1'b0, `TTBC_OFS_FIFO + 8'h10, 32'h0);
        `CHK(rv, 32'h0000_00c3)
        $display("event run done");
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge REF_CLK);
        RESET <= 1'b0;
        @(posedge REF_CLK);
        t_regs;
        t_end;
        t_full;
        t_begin;
        t_wrap;
        t_loop;
        t_event;
        complete_run;
    end
endmodule
